// [design/tcu_pkg.sv]
package tcu_pkg;
    localparam int          NCH        = 8;
    localparam int          AW         = 12;
    // register indices; byte address is four times the index
    localparam logic [9:0]  IDX_ROLE   = 10'h080;
    localparam logic [9:0]  IDX_FORCE  = 10'h081;
    localparam logic [9:0]  IDX_MMASK  = 10'h082;
    localparam logic [9:0]  IDX_MDATA  = 10'h083;
    localparam logic [9:0]  IDX_CNT    = 10'h084;
    localparam logic [9:0]  IDX_SYSCTL = 10'h086;
    localparam logic [9:0]  IDX_ACT_U  = 10'h088;
    localparam logic [9:0]  IDX_ACT_L  = 10'h089;
    localparam logic [9:0]  IDX_EDG_U  = 10'h08A;
    localparam logic [9:0]  IDX_EDG_L  = 10'h08B;
    localparam logic [9:0]  IDX_MODE2  = 10'h08D;
    localparam logic [9:0]  IDX_FLG1   = 10'h08E;
    localparam logic [9:0]  IDX_FLG2   = 10'h08F;
    localparam logic [9:0]  IDX_CH0    = 10'h090;
    localparam logic [9:0]  IDX_PACTL  = 10'h0A0;
    localparam logic [9:0]  IDX_PAFLG  = 10'h0A1;
    localparam logic [9:0]  IDX_ACCUMULATOR_COUNT  = 10'h0A2;
    localparam logic [9:0]  IDX_PDATA  = 10'h0AE;
    localparam logic [9:0]  IDX_PDIR   = 10'h0AF;
    // field positions
    localparam int          B_RUN      = 7;
    localparam int          B_HWAIT    = 6;
    localparam int          B_HDBG     = 5;
    localparam int          B_FFCA     = 4;
    localparam int          B_COUNTER_CLEAR_ON_MASTER     = 3;
    localparam int          B_TOF      = 7;
    localparam int          B_PAEN     = 6;
    localparam int          B_ACCUMULATOR_OVERFLOW_FLAG    = 1;
    localparam int          B_ACCUMULATOR_EDGE_FLAG     = 0;
    localparam int          MCH        = 7;
    // reset values and codes
    localparam logic [7:0]  RST8       = 8'h00;
    localparam logic [15:0] RST16      = 16'h0000;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;
    localparam logic [5:0]  PRE_LAST   = 6'h3F;
    localparam logic [1:0]  ACT_TGL    = 2'h1;
    localparam logic [1:0]  ACT_OFF    = 2'h0;
endpackage

// [design/tcu_top.sv]
`timescale 1ns/1ps
module tcu_top (
    input  wire logic               CLK,
    input  wire logic               SYS_RST,
    input  wire logic               PSEL,
    input  wire logic               PENABLE,
    input  wire logic               PWRITE,
    input  wire logic [tcu_pkg::AW-1:0] PADDR,
    input  wire logic [31:0]        PWDATA,
    output logic      [31:0]        PRDATA,
    output logic                    PREADY,
    output logic                    PSLVERR,
    input  wire logic               SPECIAL_MODE,
    input  wire logic               WAIT_MODE,
    input  wire logic               DEBUG_MODE,
    input  wire logic [7:0]         TP_IN,
    output logic      [7:0]         TP_OUT,
    output logic      [7:0]         TP_OE,
    output logic                    PA_DIV64_TICK
);
    import tcu_pkg::*;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0]  role_q, mmask_q, mdata_q, act_u_q, act_l_q;
    logic [7:0]  edg_u_q, edg_l_q, sysctl_q, flg1_q, pdata_q, pdir_q;
    logic [7:0]  oc_q, pin_prev_q;
    logic        counter_clear_on_master_q, tof_q, paen_q, accumulator_overflow_flag_q, accumulator_edge_flag_q;
    logic [15:0] cnt_q, accumulator_count_q;
    logic [15:0] tc_q [NCH];
    logic [5:0]  pre_q;
    logic        pready_q;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire [9:0]  idx     = PADDR[AW-1:2];
    wire        acc     = PSEL & PENABLE & pready_q;
    wire        wr      = acc & PWRITE;
    wire        rd      = acc & ~PWRITE;
    wire        h_role  = idx == IDX_ROLE;
    wire        h_force = idx == IDX_FORCE;
    wire        h_mmask = idx == IDX_MMASK;
    wire        h_mdata = idx == IDX_MDATA;
    wire        h_cnt   = idx == IDX_CNT;
    wire        h_sys   = idx == IDX_SYSCTL;
    wire        h_actu  = idx == IDX_ACT_U;
    wire        h_actl  = idx == IDX_ACT_L;
    wire        h_edgu  = idx == IDX_EDG_U;
    wire        h_edgl  = idx == IDX_EDG_L;
    wire        h_mode2 = idx == IDX_MODE2;
    wire        h_flg1  = idx == IDX_FLG1;
    wire        h_flg2  = idx == IDX_FLG2;
    wire        h_pactl = idx == IDX_PACTL;
    wire        h_paflg = idx == IDX_PAFLG;
    wire        h_accumulator_count = idx == IDX_ACCUMULATOR_COUNT;
    wire        h_pdata = idx == IDX_PDATA;
    wire        h_pdir  = idx == IDX_PDIR;
    wire [7:0]  h_ch;
    wire        h_any   = h_role | h_force | h_mmask | h_mdata | h_cnt | h_sys
                        | h_actu | h_actl | h_edgu | h_edgl | h_mode2 | h_flg1
                        | h_flg2 | h_pactl | h_paflg | h_accumulator_count | h_pdata
                        | h_pdir | (|h_ch);

    // ------------------------------------------------------------
    // timer activity and shared events
    // ------------------------------------------------------------
    wire        ffca    = sysctl_q[B_FFCA];
    wire        active  = sysctl_q[B_RUN]
                        & ~(WAIT_MODE & sysctl_q[B_HWAIT])
                        & ~(DEBUG_MODE & sysctl_q[B_HDBG]);
    wire [7:0]  force_v = (wr & h_force) ? PWDATA[7:0] : RST8;
    wire [7:0]  match;
    wire [7:0]  cap;
    wire [15:0] act_all = {act_u_q, act_l_q};
    wire [15:0] edg_all = {edg_u_q, edg_l_q};
    wire        m_fire  = match[MCH] | force_v[MCH];
    wire        cnt_wr  = wr & h_cnt & SPECIAL_MODE;
    wire        cnt_clr = counter_clear_on_master_q & match[MCH];
    wire        ovf     = active & ~cnt_wr & ~cnt_clr & (cnt_q == CNT_MAX);
    wire [7:0]  owned;

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    for (genvar n = 0; n < NCH; n++) begin : g_ch
        wire [1:0] act  = act_all[2*n +: 2];
        wire [1:0] edg  = edg_all[2*n +: 2];
        wire       rise = ~pin_prev_q[n] & TP_IN[n];
        wire       fall = pin_prev_q[n] & ~TP_IN[n];
        wire       fire = match[n] | force_v[n];
        wire       m7   = m_fire & mmask_q[n];
        logic      oc_d;
        wire       clr  = (wr & h_flg1 & PWDATA[n])
                        | (ffca & h_ch[n] & (role_q[n] ? wr : rd));
        wire       tc_wr = wr & h_ch[n] & role_q[n];

        assign h_ch[n]  = idx == (IDX_CH0 + 10'(2 * n));
        assign match[n] = active & role_q[n] & (cnt_q == tc_q[n]);
        assign cap[n]   = active & ~role_q[n]
                        & ((edg[0] & rise) | (edg[1] & fall));
        // compare ownership overrides the direction bit
        assign owned[n] = (act != ACT_OFF)
                        | (mmask_q[n] & role_q[n]);

        always_comb begin
            if (m7)
                oc_d = mdata_q[n];
            else if (fire && act == ACT_TGL)
                oc_d = ~oc_q[n];
            else if (fire && act[1])
                oc_d = act[0];
            else
                oc_d = oc_q[n];
        end

        always_ff @(posedge CLK) begin
            if (SYS_RST) begin
                tc_q[n]   <= RST16;
                flg1_q[n] <= 1'b0;
                oc_q[n]   <= 1'b0;
            end else begin
                if (cap[n])
                    tc_q[n] <= cnt_q;
                else if (tc_wr)
                    tc_q[n] <= PWDATA[15:0];
                // hardware set wins over a same-cycle clear
                flg1_q[n] <= match[n] | cap[n] | (flg1_q[n] & ~clr);
                oc_q[n]   <= oc_d;
            end
        end
    end

    // ------------------------------------------------------------
    // counter, prescaler, overflow
    // ------------------------------------------------------------
    // a counter write leaves the prescaler phase alone, so the first
    // divide-by-64 period after it keeps its full length
    logic [15:0] cnt_d;
    always_comb begin
        if (cnt_wr)
            cnt_d = PWDATA[15:0];
        else if (!active)
            cnt_d = cnt_q;
        else if (cnt_clr)
            cnt_d = RST16;
        else
            cnt_d = cnt_q + 16'h0001;
    end

    wire tof_clr  = (wr & h_flg2 & PWDATA[B_TOF]) | (ffca & acc & h_cnt);
    wire pa_edge  = paen_q & ~pin_prev_q[MCH] & TP_IN[MCH];
    wire pa_wr    = wr & h_accumulator_count;
    wire pa_ovf   = pa_edge & ~pa_wr & (accumulator_count_q == CNT_MAX);
    wire pa_fclr  = ffca & acc & h_accumulator_count;
    wire pa_oclr  = (wr & h_paflg & PWDATA[B_ACCUMULATOR_OVERFLOW_FLAG]) | pa_fclr;
    wire pa_iclr  = (wr & h_paflg & PWDATA[B_ACCUMULATOR_EDGE_FLAG]) | pa_fclr;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cnt_q         <= RST16;
            pre_q         <= '0;
            tof_q         <= 1'b0;
            PA_DIV64_TICK <= 1'b0;
            accumulator_count_q       <= RST16;
            accumulator_overflow_flag_q       <= 1'b0;
            accumulator_edge_flag_q        <= 1'b0;
            pin_prev_q    <= RST8;
        end else begin
            cnt_q         <= cnt_d;
            pre_q         <= active ? pre_q + 6'h01 : pre_q;
            PA_DIV64_TICK <= active & (pre_q == PRE_LAST);
            tof_q         <= ovf | (tof_q & ~tof_clr);
            accumulator_count_q       <= pa_wr ? PWDATA[15:0]
                           : pa_edge ? accumulator_count_q + 16'h0001 : accumulator_count_q;
            accumulator_overflow_flag_q       <= pa_ovf | (accumulator_overflow_flag_q & ~pa_oclr);
            accumulator_edge_flag_q        <= pa_edge | (accumulator_edge_flag_q & ~pa_iclr);
            pin_prev_q    <= TP_IN;
        end
    end

    // ------------------------------------------------------------
    // control registers and port
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            role_q   <= RST8;
            mmask_q  <= RST8;
            mdata_q  <= RST8;
            act_u_q  <= RST8;
            act_l_q  <= RST8;
            edg_u_q  <= RST8;
            edg_l_q  <= RST8;
            sysctl_q <= RST8;
            counter_clear_on_master_q   <= 1'b0;
            paen_q   <= 1'b0;
            pdata_q  <= RST8;
            pdir_q   <= RST8;
        end else if (wr) begin
            if (h_role)  role_q   <= PWDATA[7:0];
            if (h_mmask) mmask_q  <= PWDATA[7:0];
            if (h_mdata) mdata_q  <= PWDATA[7:0];
            if (h_actu)  act_u_q  <= PWDATA[7:0];
            if (h_actl)  act_l_q  <= PWDATA[7:0];
            if (h_edgu)  edg_u_q  <= PWDATA[7:0];
            if (h_edgl)  edg_l_q  <= PWDATA[7:0];
            if (h_sys)   sysctl_q <= PWDATA[7:0] & 8'hF0;
            if (h_mode2) counter_clear_on_master_q   <= PWDATA[B_COUNTER_CLEAR_ON_MASTER];
            if (h_pactl) paen_q   <= PWDATA[B_PAEN];
            if (h_pdata) pdata_q  <= PWDATA[7:0];
            if (h_pdir)  pdir_q   <= PWDATA[7:0];
        end
    end

    // owned pins ignore the latch; it shows again once released
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            TP_OUT <= RST8;
            TP_OE  <= RST8;
        end else begin
            TP_OUT <= (owned & oc_q) | (~owned & pdata_q);
            TP_OE  <= owned | pdir_q;
        end
    end

    // ------------------------------------------------------------
    // read mux and bus answer
    // ------------------------------------------------------------
    logic [15:0] rdata;
    always_comb begin
        rdata = RST16;
        if (h_role)       rdata = {8'h00, role_q};
        else if (h_force) rdata = RST16;
        else if (h_mmask) rdata = {8'h00, mmask_q};
        else if (h_mdata) rdata = {8'h00, mdata_q};
        else if (h_cnt)   rdata = cnt_q;
        else if (h_sys)   rdata = {8'h00, sysctl_q};
        else if (h_actu)  rdata = {8'h00, act_u_q};
        else if (h_actl)  rdata = {8'h00, act_l_q};
        else if (h_edgu)  rdata = {8'h00, edg_u_q};
        else if (h_edgl)  rdata = {8'h00, edg_l_q};
        else if (h_mode2) rdata = {8'h00, 4'h0, counter_clear_on_master_q, 3'h0};
        else if (h_flg1)  rdata = {8'h00, flg1_q};
        else if (h_flg2)  rdata = {8'h00, tof_q, 7'h00};
        else if (h_pactl) rdata = {8'h00, 1'b0, paen_q, 6'h00};
        else if (h_paflg) rdata = {8'h00, 6'h00, accumulator_overflow_flag_q, accumulator_edge_flag_q};
        else if (h_accumulator_count) rdata = accumulator_count_q;
        else if (h_pdata) rdata = {8'h00, (pdir_q & pdata_q) | (~pdir_q & TP_IN)};
        else if (h_pdir)  rdata = {8'h00, pdir_q};
        else begin
            for (int k = 0; k < NCH; k++) begin
                if (h_ch[k])
                    rdata = tc_q[k];
            end
        end
    end

    // no wait state: data is registered in the setup cycle
    wire setup = PSEL & ~PENABLE;
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pready_q <= 1'b0;
            PREADY   <= 1'b0;
            PRDATA   <= '0;
            PSLVERR  <= 1'b0;
        end else begin
            pready_q <= setup;
            PREADY   <= setup;
            PRDATA   <= setup ? {16'h0000, rdata} : '0;
            PSLVERR  <= setup & ~h_any;
        end
    end
endmodule

// [dv/tcu_pin_model.sv]
`timescale 1ns/1ps
module tcu_pin_model (
    input  wire logic [7:0] tp_out,
    input  wire logic [7:0] tp_oe,
    input  wire logic [7:0] ext_drv,
    output logic      [7:0] tp_in
);
    // a pin the timer drives reads back its own level, the rest follow the source
    assign tp_in = (tp_oe & tp_out) | (~tp_oe & ext_drv);
endmodule

// [dv/tcu_monitor.sv]
`timescale 1ns/1ps
module tcu_monitor (
    input  wire logic                    CLK,
    input  wire logic                    SYS_RST,
    input  wire logic                    PSEL,
    input  wire logic                    PENABLE,
    input  wire logic                    PWRITE,
    input  wire logic [tcu_pkg::AW-1:0]  PADDR,
    input  wire logic [31:0]             PWDATA,
    input  wire logic [31:0]             PRDATA,
    input  wire logic                    PREADY,
    input  wire logic                    PSLVERR,
    input  wire logic                    WAIT_MODE,
    input  wire logic                    DEBUG_MODE,
    input  wire logic [7:0]              TP_OUT,
    input  wire logic [7:0]              TP_OE,
    input  wire logic                    PA_DIV64_TICK
);
    import tcu_pkg::*;
    // -----------------------------------------
    // register shadows taken from the bus
    // -----------------------------------------
    logic [7:0]  role_q, mask_q, dir_q, pdat_q, ctl_q, gap_q, nz_v, own_v;
    logic [15:0] act_q;
    wire         wr = PSEL & PENABLE & PREADY & PWRITE;
    wire  [9:0]  idx = PADDR[AW-1:2];
    wire         stop_v = !ctl_q[B_RUN] | (ctl_q[B_HWAIT] & WAIT_MODE)
                          | (ctl_q[B_HDBG] & DEBUG_MODE);
    always_comb begin
        for (int n = 0; n < NCH; n++) begin
            nz_v[n] = |act_q[2*n +: 2];
        end
    end
    assign own_v = nz_v | (mask_q & role_q);
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            {role_q, mask_q, dir_q, pdat_q, ctl_q, act_q, gap_q} <= '0;
        end else begin
            // saturating, so a long stop never wraps into a false short gap
            gap_q <= PA_DIV64_TICK ? 8'h00 : (gap_q == 8'hFF ? gap_q : gap_q + 8'h01);
            if (wr && idx == IDX_ROLE) role_q <= PWDATA[7:0];
            if (wr && idx == IDX_MMASK) mask_q <= PWDATA[7:0];
            if (wr && idx == IDX_PDIR) dir_q <= PWDATA[7:0];
            if (wr && idx == IDX_PDATA) pdat_q <= PWDATA[7:0];
            if (wr && idx == IDX_SYSCTL) ctl_q <= PWDATA[7:0];
            if (wr && idx == IDX_ACT_U) act_q[15:8] <= PWDATA[7:0];
            if (wr && idx == IDX_ACT_L) act_q[7:0] <= PWDATA[7:0];
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("ready missing after setup");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");
    a_err_no_data: assert property (PSLVERR |-> PRDATA == 32'h0)
        else $error("error response carries data");
    a_force_reads_zero: assert property (
        PREADY && !PWRITE && idx == IDX_FORCE |-> PRDATA == 32'h0)
        else $error("force register read nonzero");
    a_no_tick_stopped: assert property (
        stop_v && $past(stop_v) |-> !PA_DIV64_TICK) else $error("tick while stopped");
    a_tick_gap: assert property (PA_DIV64_TICK |-> gap_q >= 8'h3F)
        else $error("tick spacing below 64");
    a_oe_owned: assert property (
        (own_v | dir_q) == $past(own_v | dir_q) |-> TP_OE == (own_v | dir_q))
        else $error("pin enable wrong");
    a_out_latch: assert property (
        {own_v, pdat_q} == $past({own_v, pdat_q}) |-> ((TP_OUT ^ pdat_q) & ~own_v) == 8'h00)
        else $error("free pin not driving latch");
endmodule
bind tcu_top tcu_monitor u_mon (.CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .WAIT_MODE, .DEBUG_MODE, .TP_OUT, .TP_OE, .PA_DIV64_TICK);

// [dv/timer_capture_compare_unit_tb_top.sv]
`timescale 1ns/1ps
module timer_capture_compare_unit_tb_top;
    import tcu_pkg::*;
    localparam logic [32:0] ALL = 33'h1_FFFF_FFFF;
    logic        clk, sys_rst, psel, penable, pwrite, spec, wmode, dmode, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rnd, seed;
    logic [7:0]  tp_in, tp_out, tp_oe, ext;
    logic [32:0] exp_q[$], msk_q[$];
    logic [9:0]  rwi[4] = '{IDX_ROLE, IDX_MMASK, IDX_MDATA, IDX_EDG_U};
    logic [9:0]  zi[7] = '{IDX_ROLE, IDX_FORCE, IDX_MMASK, IDX_ACT_U, IDX_ACT_L,
                           IDX_FLG1, IDX_FLG2};
    int          n_mismatch, n_compared;
    tcu_top DUT (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SPECIAL_MODE(spec), .WAIT_MODE(wmode), .DEBUG_MODE(dmode),
        .TP_IN(tp_in), .TP_OUT(tp_out), .TP_OE(tp_oe), .PA_DIV64_TICK());
    tcu_pin_model u_pins (.tp_out(tp_out), .tp_oe(tp_oe), .ext_drv(ext), .tp_in(tp_in));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [32:0] got, input logic [32:0] e);
        n_compared++;
        if (got !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask
    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'h0};
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rd(input logic [9:0] idx, input logic [32:0] e, input logic [32:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        apb(1'b0, idx, 32'h0);
    endtask
    task automatic pins(input logic [15:0] e);
        @(posedge clk);
        chk(33'({tp_oe, tp_out}), 33'(e));
    endtask
    task automatic print_verdict();
        $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ---------------------------------
    // read results checked in order
    // ---------------------------------
    always @(posedge clk) begin
        if ((psel & penable & pready & ~pwrite) === 1'b1 && exp_q.size() > 0) begin
            chk({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
        end
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        seed = 32'h0000BB17;
        {psel, penable, pwrite, spec, wmode, dmode, paddr, pwdata, ext} = '0;
        sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        foreach (zi[i]) rd(zi[i], 33'h0, ALL);
        rd(10'h085, 33'h1_0000_0000, ALL);
        foreach (rwi[i]) begin
            rnd = xs();
            wr(rwi[i], rnd);
            rd(rwi[i], {25'h0, rnd[7:0]}, ALL);
        end
        wr(IDX_MMASK, 32'h0);
        wr(IDX_FORCE, xs() & 32'h7F);
        rd(IDX_FORCE, 33'h0, ALL);
        wr(IDX_CNT, 32'h1234);
        rd(IDX_CNT, 33'h0, ALL);
        spec <= 1'b1;
        wr(IDX_CNT, 32'hFFF0);
        rd(IDX_CNT, 33'hFFF0, ALL);
        wmode <= 1'b1;
        dmode <= 1'b1;
        wr(IDX_SYSCTL, 32'h80);
        repeat (80) @(posedge clk);
        wr(IDX_SYSCTL, 32'h00);
        rd(IDX_FLG2, 33'h80, 33'h80);
        wr(IDX_FLG2, 32'h0);
        rd(IDX_FLG2, 33'h80, 33'h80);
        wr(IDX_SYSCTL, 32'h10);
        // 83 counting edges from FFF0, stop edge included, enable edge not
        rd(IDX_CNT, 33'h0043, ALL);
        rd(IDX_FLG2, 33'h0, 33'h80);
        wr(IDX_CNT, 32'h0100);
        repeat (20) @(posedge clk);
        rd(IDX_CNT, 33'h0100, ALL);
        wr(IDX_SYSCTL, 32'hC0);
        repeat (20) @(posedge clk);
        rd(IDX_CNT, 33'h0100, ALL);
        wr(IDX_SYSCTL, 32'hA0);
        repeat (20) @(posedge clk);
        rd(IDX_CNT, 33'h0100, ALL);
        wr(IDX_SYSCTL, 32'h00);
        wr(IDX_ROLE, 32'hFF);
        wr(IDX_ACT_U, 32'h1B);
        wr(IDX_ACT_L, 32'hE4);
        wr(IDX_FLG1, 32'hFF);
        wr(IDX_FORCE, 32'h7F);
        pins(16'h7E5A);
        rd(IDX_FLG1, 33'h0, ALL);
        wr(IDX_FORCE, 32'h7F);
        pins(16'h7E18);
        wr(IDX_MMASK, 32'h0C);
        wr(IDX_MDATA, 32'h04);
        wr(IDX_FORCE, 32'h8C);
        pins(16'h7E14);
        wr(IDX_PDATA, 32'hA5);
        pins(16'h7E95);
        wr(IDX_ACT_U, 32'h0);
        wr(IDX_ACT_L, 32'h0);
        wr(IDX_MMASK, 32'h0);
        wr(IDX_PDIR, 32'hF0);
        pins(16'hF0A5);
        wr(IDX_FLG1, 32'hFF);
        wr(IDX_CH0 + 10'h008, 32'h0120);
        wr(IDX_SYSCTL, 32'h90);
        repeat (40) @(posedge clk);
        wr(IDX_SYSCTL, 32'h10);
        rd(IDX_FLG1, 33'h10, 33'h10);
        wr(IDX_CH0 + 10'h008, 32'h0120);
        rd(IDX_FLG1, 33'h00, 33'h10);
        wr(IDX_ROLE, 32'h00);
        wr(IDX_PDIR, 32'h00);
        wr(IDX_EDG_L, 32'h1B);
        // captures need a running timer; counter moves on after the write
        wr(IDX_SYSCTL, 32'h80);
        wr(IDX_CNT, 32'h4321);
        wr(IDX_FLG1, 32'hFF);
        ext <= 8'h0F;
        repeat (3) @(posedge clk);
        rd(IDX_FLG1, 33'h05, 33'h0F);
        ext <= 8'h00;
        repeat (3) @(posedge clk);
        rd(IDX_FLG1, 33'h07, 33'h0F);
        // rising-only channel keeps its first capture: write value plus four counts
        rd(IDX_CH0 + 10'h004, 33'h4325, ALL);
        wr(IDX_SYSCTL, 32'h00);
        wr(IDX_ROLE, 32'h80);
        wr(IDX_CH0 + 10'h00E, 32'h0005);
        wr(IDX_MODE2, 32'h08);
        wr(IDX_CNT, 32'h0000);
        wr(IDX_FLG1, 32'hFF);
        wr(IDX_SYSCTL, 32'h80);
        repeat (10) @(posedge clk);
        wr(IDX_SYSCTL, 32'h00);
        // 13 counting edges through a six-count period 0..5
        rd(IDX_CNT, 33'h0001, ALL);
        rd(IDX_FLG1, 33'h80, 33'h80);
        wr(IDX_PACTL, 32'h40);
        ext <= 8'h80;
        repeat (2) @(posedge clk);
        rd(IDX_PAFLG, 33'h01, ALL);
        rd(IDX_PDATA, 33'h80, ALL);
        wr(IDX_SYSCTL, 32'h10);
        rd(IDX_ACCUMULATOR_COUNT, 33'h0001, ALL);
        rd(IDX_PAFLG, 33'h00, ALL);
        repeat (3) @(posedge clk);
        print_verdict();
    end
endmodule
